// >>> hdl/uaf_consts.vh
// Constants for the serial transceiver address filter and register block.
// Assumes inclusion by plain Verilog-2005 design files only.
`ifndef UAF_CONSTS_VH
`define UAF_CONSTS_VH
// Register selects on the cpu port
`define UAF_SEL_DATA 2'h0
`define UAF_SEL_CSA 2'h1
`define UAF_SEL_CSB 2'h2
`define UAF_SEL_SHARED 2'h3
// Control/status A bit positions
`define UAF_CSA_RXC 7
`define UAF_CSA_TXC 6
`define UAF_CSA_TXE 5
`define UAF_CSA_FE 4
`define UAF_CSA_DOR 3
`define UAF_CSA_PE 2
`define UAF_CSA_U2X 1
`define UAF_CSA_MPC 0
`define UAF_CSA_RESET 8'h20
// Control B bit positions (own layout)
`define UAF_CSB_RXCIE 7
`define UAF_CSB_TXCIE 6
`define UAF_CSB_RXEN 4
`define UAF_CSB_TXEN 3
`define UAF_CSB_SZ2 2
`define UAF_CSB_RX9 1
`define UAF_CSB_TX9 0
// Shared location
`define UAF_SEL_BIT 7
`define UAF_CSC_RESET 8'h86
`define UAF_CSC_STOP2 3
`define UAF_CSC_SYNC 6
// Baud timing
`define UAF_OVS_NORMAL 5'h10
`define UAF_OVS_DOUBLE 5'h08
`endif

// >>> hdl/uaf_fifo2.v
// Two-entry receive FIFO; each entry holds data, ninth bit and error flags.
// Assumes one clock; push and pop are single-cycle strobes from the owner.
`timescale 1ns/100ps
module uaf_fifo2 (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire flush_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [11:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output reg [11:0] out_data_o
);
  reg [11:0] mem [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire push;
  wire pop;

  // Handshake terms
  assign in_ready_o = (count != 2'h2);
  assign out_valid_o = (count != 2'h0);
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  // Storage, pointers and registered head
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      out_data_o <= 12'h000;
      mem[0] <= 12'h000;
      mem[1] <= 12'h000;
    end else if (flush_i) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'h0;
      out_data_o <= 12'h000;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data_i;
        wr_ptr <= ~wr_ptr;
      end
      if (pop) begin
        rd_ptr <= ~rd_ptr;
      end
      count <= count + {1'b0, push} - {1'b0, pop};
      // Head register tracks the next entry to be read
      if (pop && count == 2'h2) begin
        out_data_o <= mem[~rd_ptr];
      end else if (push && (count == 2'h0 || (pop && count == 2'h1))) begin
        out_data_o <= in_data_i;
      end
    end
  end
endmodule

// >>> hdl/uaf_usart.v
// Serial transceiver: address filter, register port, tx buffer, rx FIFO.
// Assumes a cpu port with single-cycle rd/wr strobes and an async line in.
// Functional notes
// - Filter drops non-address frames when enabled
// - Five to eight bits: first stop marks type
// - Nine bits: ninth bit marks type
// - Type one is address, zero data
// - Transmitter ignores filter enable
// - Shared write chooses by top bit
// - Back-to-back read returns control C
// - Data write to tx, read from rx
// - Unused upper bits ignored, read zero
// - Write while tx full is ignored
// - Buffer moves to shifter when empty
// - Receive FIFO two entries, any access advances
// - Rx complete tracks buffer; disable flushes
// - Tx complete sets on idle, write-one clears
// - Tx empty flag, one after reset
// - Framing flag from head stop bit
// - Overrun when full, shifter waits, start
// - Double rate halves oversample divisor
// - Rx interrupt needs enable, global, flag
`timescale 1ns/100ps
`include "uaf_consts.vh"
module uaf_usart (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire [1:0] reg_sel_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire global_int_en_i,
  input wire txc_int_ack_i,
  input wire serial_in_pin_i,
  output reg serial_out_pin_o,
  output wire rx_int_o,
  output wire txc_int_o
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg mpc;
  reg u2x;
  reg tx_complete;
  reg [7:0] csb;
  reg [7:0] csc;
  reg [3:0] baud_div_high;
  reg [7:0] baud_div_low;
  reg shared_rd_last;
  reg [8:0] tx_buf;
  reg tx_full;
  reg in_s1, in_s2;
  wire rx_en = csb[`UAF_CSB_RXEN];
  wire tx_en = csb[`UAF_CSB_TXEN];
  wire nine = csb[`UAF_CSB_SZ2] & (csc[2:1] == 2'h3);
  wire [3:0] nbits = nine ? 4'h9 : {2'b00, csc[2:1]} + 4'h5;
  wire [4:0] ovs = u2x ? `UAF_OVS_DOUBLE : `UAF_OVS_NORMAL;
  wire [11:0] baud_div = {baud_div_high, baud_div_low};

  // Receive FIFO wires
  wire fifo_in_ready, fifo_out_valid;
  wire [11:0] fifo_head;
  reg rx_hold;
  reg [11:0] rx_hold_data;
  reg dor_pending;
  wire data_rd = reg_rd_i && reg_sel_i == `UAF_SEL_DATA;
  wire data_access = (reg_rd_i | reg_wr_i) && reg_sel_i == `UAF_SEL_DATA;

  // Head of FIFO pops on any access to the data location
  uaf_fifo2 u_fifo (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .flush_i(~rx_en),
    .in_valid_i(rx_hold),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rx_hold_data),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(data_access),
    .out_data_o(fifo_head)
  );

  // Interrupt requests
  assign rx_int_o = csb[`UAF_CSB_RXCIE] & global_int_en_i & fifo_out_valid;
  assign txc_int_o = csb[`UAF_CSB_TXCIE] & global_int_en_i & tx_complete;

  // ----------------------------------------------------------------
  // Baud tick generator
  // ----------------------------------------------------------------
  reg [11:0] baud_cnt;
  reg os_tick;
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      baud_cnt <= 12'h000;
      os_tick <= 1'b0;
    end else begin
      os_tick <= (baud_cnt == 12'h000);
      baud_cnt <= (baud_cnt == 12'h000) ? baud_div : baud_cnt - 12'h001;
    end
  end

  // ----------------------------------------------------------------
  // Transmitter: buffer into shifter, frame out
  // ----------------------------------------------------------------
  reg [11:0] tx_sr;
  reg [3:0] tx_left;
  reg [4:0] tx_os;
  reg tx_busy;
  wire tx_frame_done = tx_busy && os_tick && tx_os == 5'h00 && tx_left == 4'h0;
  wire [3:0] stop_n = csc[`UAF_CSC_STOP2] ? 4'h2 : 4'h1;
  reg [8:0] tx_mask;
  integer i;
  always @* begin
    for (i = 0; i < 9; i = i + 1) begin
      tx_mask[i] = (i < nbits);
    end
  end
  wire [8:0] tx_bits = tx_buf & tx_mask;
  wire tx_load = tx_en && tx_full && (!tx_busy || tx_frame_done);
  wire data_wr = reg_wr_i && reg_sel_i == `UAF_SEL_DATA;

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_sr <= 12'hFFF;
      tx_left <= 4'h0;
      tx_os <= 5'h00;
      tx_busy <= 1'b0;
      serial_out_pin_o <= 1'b1;
      tx_buf <= 9'h000;
      tx_full <= 1'b0;
    end else begin
      if (data_wr && !tx_full) begin
        tx_buf <= {csb[`UAF_CSB_TX9], reg_wdata_i};
        tx_full <= 1'b1;
      end else if (tx_load) begin
        tx_full <= 1'b0;
      end
      if (tx_load) begin
        // Data LSB first, then stop bits; ninth bit rides at position 8
        tx_sr <= {3'h7, tx_bits} >> 0;
        tx_left <= nbits + stop_n;
        tx_os <= ovs - 5'h01;
        tx_busy <= 1'b1;
        serial_out_pin_o <= 1'b0;
      end else if (tx_frame_done) begin
        tx_busy <= 1'b0;
        serial_out_pin_o <= 1'b1;
      end else if (tx_busy && os_tick) begin
        if (tx_os == 5'h00) begin
          tx_os <= ovs - 5'h01;
          tx_left <= tx_left - 4'h1;
          serial_out_pin_o <= (tx_left > stop_n) ? tx_sr[0] : 1'b1;
          tx_sr <= {1'b1, tx_sr[11:1]};
        end else begin
          tx_os <= tx_os - 5'h01;
        end
      end
      if (!tx_en && !tx_busy) begin
        serial_out_pin_o <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Receiver: sample, assemble, classify, filter
  // ----------------------------------------------------------------
  reg [1:0] rx_st;
  localparam RX_IDLE = 2'h0;
  localparam RX_START = 2'h1;
  localparam RX_BITS = 2'h2;
  reg [4:0] rx_os;
  reg [3:0] rx_idx;
  reg [8:0] rx_sr;
  reg par_bit;
  wire parity_en = csc[5];
  wire [3:0] rx_total = nbits + {3'h0, parity_en};
  wire [4:0] half = {1'b0, ovs[4:1]};
  wire rx_at_stop = (rx_idx == rx_total);
  wire stop_bit = in_s2;
  wire type_bit = nine ? rx_sr[8] : stop_bit;
  wire is_addr = type_bit;
  wire par_err = parity_en & ((^(rx_sr & tx_mask)) ^ par_bit ^ csc[4]);

  // Line synchroniser
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_s1 <= 1'b1;
      in_s2 <= 1'b1;
    end else begin
      in_s1 <= serial_in_pin_i;
      in_s2 <= in_s1;
    end
  end

  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_st <= RX_IDLE;
      rx_os <= 5'h00;
      rx_idx <= 4'h0;
      rx_sr <= 9'h000;
      par_bit <= 1'b0;
      rx_hold <= 1'b0;
      rx_hold_data <= 12'h000;
      dor_pending <= 1'b0;
    end else if (!rx_en) begin
      rx_st <= RX_IDLE;
      rx_hold <= 1'b0;
      dor_pending <= 1'b0;
    end else begin
      // Shift register waits until the FIFO has room
      if (rx_hold && fifo_in_ready) begin
        rx_hold <= 1'b0;
        dor_pending <= 1'b0;
      end
      case (rx_st)
        RX_IDLE: begin
          if (!in_s2) begin
            if (rx_hold && !fifo_in_ready) begin
              dor_pending <= 1'b1;
            end
            rx_st <= RX_START;
            rx_os <= half;
          end
        end
        RX_START: begin
          if (os_tick) begin
            if (rx_os == 5'h00) begin
              rx_st <= in_s2 ? RX_IDLE : RX_BITS;
              rx_os <= ovs - 5'h01;
              rx_idx <= 4'h0;
              rx_sr <= 9'h000;
            end else begin
              rx_os <= rx_os - 5'h01;
            end
          end
        end
        RX_BITS: begin
          if (os_tick) begin
            if (rx_os == 5'h00) begin
              rx_os <= ovs - 5'h01;
              rx_idx <= rx_idx + 4'h1;
              if (rx_at_stop) begin
                rx_st <= RX_IDLE;
                // Non-address frames dropped while filtering
                if (!mpc || is_addr) begin
                  rx_hold <= 1'b1;
                  // Entry: {pe, dor, fe, ninth, data}; upper bits zero
                  rx_hold_data <= {par_err, dor_pending, ~stop_bit, rx_sr & tx_mask};
                end
              end else if (rx_idx < nbits) begin
                rx_sr[rx_idx] <= in_s2;
              end else begin
                par_bit <= in_s2;
              end
            end else begin
              rx_os <= rx_os - 5'h01;
            end
          end
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers and shared location
  // ----------------------------------------------------------------
  wire csa_wr = reg_wr_i && reg_sel_i == `UAF_SEL_CSA;
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mpc <= 1'b0;
      u2x <= 1'b0;
      tx_complete <= 1'b0;
      csb <= 8'h00;
      csc <= `UAF_CSC_RESET;
      baud_div_high <= 4'h0;
      baud_div_low <= 8'h00;
      shared_rd_last <= 1'b0;
    end else begin
      shared_rd_last <= reg_rd_i && reg_sel_i == `UAF_SEL_SHARED;
      if (csa_wr) begin
        mpc <= reg_wdata_i[`UAF_CSA_MPC];
        u2x <= reg_wdata_i[`UAF_CSA_U2X];
      end
      // Completion set wins over ack or write-one clear
      if (tx_frame_done && !tx_full) begin
        tx_complete <= 1'b1;
      end else if (txc_int_ack_i || (csa_wr && reg_wdata_i[`UAF_CSA_TXC])) begin
        tx_complete <= 1'b0;
      end
      if (reg_wr_i && reg_sel_i == `UAF_SEL_CSB) begin
        csb <= reg_wdata_i;
      end
      if (reg_wr_i && reg_sel_i == `UAF_SEL_SHARED) begin
        if (reg_wdata_i[`UAF_SEL_BIT]) begin
          csc <= reg_wdata_i;
        end else begin
          baud_div_high <= reg_wdata_i[3:0];
        end
      end
      // Low baud byte held: a shared-select write with top bit zero keeps its value
      if (reg_wr_i && reg_sel_i == `UAF_SEL_SHARED && !reg_wdata_i[`UAF_SEL_BIT]) begin
        baud_div_low <= baud_div_low;
      end
    end
  end

  // Read data mux, registered
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_sel_i)
        `UAF_SEL_DATA: reg_rdata_o <= fifo_head[7:0];
        `UAF_SEL_CSA: reg_rdata_o <= {fifo_out_valid, tx_complete, ~tx_full,
          fifo_head[9] & fifo_out_valid, fifo_head[10] & fifo_out_valid,
          fifo_head[11] & fifo_out_valid, u2x, mpc};
        `UAF_SEL_CSB: reg_rdata_o <= {csb[7:2], fifo_head[8], csb[0]};
        `UAF_SEL_SHARED: reg_rdata_o <= shared_rd_last ? {1'b1, csc[6:0]}
          : {4'h0, baud_div_high};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end
endmodule

// >>> verif/test_usart_addr_filter_regs.sv
// Self-checking bench for the transceiver's filter and register port.
// Assumes baud divisor zero, so one bit lasts sixteen clocks.
`timescale 1ns/100ps
module test_usart_addr_filter_regs;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic global_int_en_i = 1'b0, txc_int_ack_i = 1'b0;
  logic [1:0] reg_sel_i = 2'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] rv;
  logic [8:0] cd;
  wire [7:0] reg_rdata_o;
  wire serial_in_pin_i, serial_out_pin_o, rx_int_o, txc_int_o;
  int failures = 0, tests_run = 0, cyc = 0;
  uaf_usart uut (.clk_sys_i, .resetn_i, .reg_sel_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
    .reg_rdata_o, .global_int_en_i, .txc_int_ack_i, .serial_in_pin_i, .serial_out_pin_o,
    .rx_int_o, .txc_int_o);
  uaf_line_model far (.clk_sys_i, .line_i(serial_out_pin_o), .line_o(serial_in_pin_i));
  // ------------------------------
  // Bus tasks and scenarios
  // ------------------------------
  initial forever #20 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_sel_i = s;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask
  // n back-to-back reads; the last answer is returned
  task automatic rd(input logic [1:0] s, input int n, output logic [7:0] d);
    @(negedge clk_sys_i);
    reg_sel_i = s;
    reg_rd_i = 1'b1;
    repeat (n) @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    d = reg_rdata_o;
  endtask
  task automatic rc(input logic [1:0] s, input logic [7:0] e, input string nm);
    rd(s, 1, rv);
    chk(nm, rv, e);
  endtask
  task automatic t_shared();
    rc(2'h1, 8'h20, "csa_reset");
    rc(2'h3, 8'h00, "baud_reset");
    rd(2'h3, 2, rv);
    chk("csc_reset", rv, 8'h86);
    wr(2'h3, 8'h05);
    wr(2'h3, 8'h8E);
    rc(2'h3, 8'h05, "baud_wr");
    rd(2'h3, 2, rv);
    chk("csc_wr", rv, 8'h8E);
    wr(2'h3, 8'h00);
    // Baud counter still runs down the large divisor loaded above
    repeat (1300) @(negedge clk_sys_i);
  endtask
  task automatic t_filter8();
    wr(2'h2, 8'h18);
    wr(2'h1, 8'h01);
    far.send(9'h033, 8, 1'b0);
    rc(2'h1, 8'h21, "drop_data");
    far.send(9'h05A, 8, 1'b1);
    rc(2'h1, 8'hA1, "keep_addr");
    rc(2'h0, 8'h5A, "addr_byte");
    rc(2'h1, 8'h21, "popped");
    wr(2'h1, 8'h00);
    far.send(9'h03C, 8, 1'b0);
    rc(2'h1, 8'hB0, "fe_set");
    rc(2'h0, 8'h3C, "fe_byte");
    rc(2'h1, 8'h20, "fe_clear");
  endtask
  task automatic t_nine();
    wr(2'h2, 8'h1C);
    wr(2'h1, 8'h01);
    far.send(9'h077, 9, 1'b1);
    rc(2'h1, 8'h21, "drop9");
    far.send(9'h1AB, 9, 1'b1);
    rc(2'h2, 8'h1E, "ninth_bit");
    rc(2'h0, 8'hAB, "byte9");
  endtask
  task automatic t_fifo();
    wr(2'h2, 8'h98);
    wr(2'h1, 8'h00);
    far.send(9'h011, 8, 1'b1);
    far.send(9'h022, 8, 1'b1);
    chk("int_off", {7'h0, rx_int_o}, 8'h00);
    global_int_en_i = 1'b1;
    @(negedge clk_sys_i);
    chk("int_on", {7'h0, rx_int_o}, 8'h01);
    rc(2'h0, 8'h11, "head");
    rc(2'h1, 8'hA0, "second");
    wr(2'h2, 8'h88);
    rc(2'h1, 8'h20, "flushed");
    chk("int_flush", {7'h0, rx_int_o}, 8'h00);
    global_int_en_i = 1'b0;
  endtask
  task automatic t_tx();
    wr(2'h2, 8'h58);
    wr(2'h1, 8'h41);
    fork
      begin
        far.cap(cd, 8);
        chk("tx1", cd[7:0], 8'hA5);
        far.cap(cd, 8);
        chk("tx2", cd[7:0], 8'h3C);
      end
      begin
        wr(2'h0, 8'hA5);
        rc(2'h1, 8'h21, "tx_loaded");
        wr(2'h0, 8'h3C);
        wr(2'h0, 8'hFF);
        rc(2'h1, 8'h01, "tx_full");
      end
    join
    repeat (60) @(negedge clk_sys_i);
    rc(2'h1, 8'h61, "tx_done");
    global_int_en_i = 1'b1;
    @(negedge clk_sys_i);
    chk("txc_int", {7'h0, txc_int_o}, 8'h01);
    txc_int_ack_i = 1'b1;
    @(negedge clk_sys_i);
    txc_int_ack_i = 1'b0;
    rc(2'h1, 8'h21, "txc_ack");
    global_int_en_i = 1'b0;
  endtask
  task automatic t_short();
    wr(2'h3, 8'h88);
    wr(2'h1, 8'h00);
    fork
      far.cap(cd, 8);
      wr(2'h0, 8'hEA);
    join
    chk("tx5", cd[7:0], 8'hEA);
    far.send(9'h1F5, 5, 1'b1);
    rc(2'h0, 8'h15, "rx5");
    rc(2'h1, 8'h60, "txc_set");
    wr(2'h1, 8'h40);
    rc(2'h1, 8'h20, "txc_w1c");
  endtask
  // Double rate: start plus five zero bits last six bits of eight clocks
  task automatic t_double();
    int n;
    n = 0;
    wr(2'h1, 8'h02);
    fork
      begin
        wait (!serial_out_pin_o);
        @(negedge clk_sys_i);
        while (!serial_out_pin_o) begin
          n++;
          @(negedge clk_sys_i);
        end
      end
      wr(2'h0, 8'h00);
    join
    chk("u2x_low", n[7:0], 8'h30);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Cut a hang short
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end
  initial begin
    repeat (8) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    t_shared();
    t_filter8();
    t_nine();
    t_fifo();
    t_tx();
    t_short();
    t_double();
    finish_test();
  end
endmodule

// >>> verif/uaf_line_model.sv
// Far-end transceiver: sends frames to the block and captures its output.
// Assumes a bit time of BIT_CLKS system clocks; the line idles high.
`timescale 1ns/100ps
module uaf_line_model #(
  parameter int BIT_CLKS = 16
) (
  input wire clk_sys_i,
  input wire line_i,
  output logic line_o
);
  initial line_o = 1'b1;
  // Hold one level for a whole bit, changing at falling edges
  task automatic put(input logic b);
    line_o = b;
    repeat (BIT_CLKS) @(negedge clk_sys_i);
  endtask
  // Start, data LSB first, type in first stop, then a second stop
  task automatic send(input logic [8:0] d, input int n, input logic t);
    put(1'b0);
    for (int i = 0; i < n; i++) put(d[i]);
    put(t);
    put(1'b1);
  endtask
  // Sample n bits mid-bit after a start edge
  task automatic cap(output logic [8:0] d, input int n);
    d = '0;
    wait (line_i);
    wait (!line_i);
    repeat (BIT_CLKS / 2) @(posedge clk_sys_i);
    for (int i = 0; i < n; i++) begin
      repeat (BIT_CLKS) @(posedge clk_sys_i);
      d[i] = line_i;
    end
  endtask
endmodule

// >>> verif/uaf_usart_asserts.sv
// Port assertions for the serial transceiver register block.
// Assumes binding to uaf_usart; bit time is at least eight clocks.
`timescale 1ns/100ps
module uaf_usart_asserts (
  input wire clk_sys_i,
  input wire resetn_i,
  input wire [1:0] reg_sel_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire global_int_en_i,
  input wire txc_int_ack_i,
  input wire serial_in_pin_i,
  input wire serial_out_pin_o,
  input wire rx_int_o,
  input wire txc_int_o
);
  // ------------------------------
  // Register and line relations
  // ------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // A read of the shared baud-high/control-C place
  wire shr_rd = reg_rd_i && reg_sel_i == 2'h3;
  sequence shr_pair_s;
    shr_rd ##1 shr_rd;
  endsequence
  shared_pair_a: assert property (shr_pair_s |=> reg_rdata_o[7])
    else $error("back-to-back shared read missed control C");
  shared_single_a: assert property (shr_rd && !$past(shr_rd) |=> !reg_rdata_o[7])
    else $error("lone shared read missed baud high");
  rdata_hold_a: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  rx_int_gate_a: assert property (rx_int_o |-> global_int_en_i)
    else $error("rx interrupt without global enable");
  txc_int_gate_a: assert property (txc_int_o |-> global_int_en_i)
    else $error("tx interrupt without global enable");
  txc_ack_a: assert property (txc_int_ack_i && txc_int_o && serial_out_pin_o |=> !txc_int_o)
    else $error("tx complete not cleared by ack");
  // A receiver disable flushes the buffer one cycle after its control B write
  rx_int_fall_a: assert property ($fell(rx_int_o) |-> $past(reg_rd_i || reg_wr_i)
    || $past(reg_wr_i, 2) || $fell(global_int_en_i))
    else $error("rx complete dropped with no access");
  bit_len_a: assert property ($fell(serial_out_pin_o) |-> (!serial_out_pin_o) [*8])
    else $error("line low shorter than a bit");
endmodule
bind uaf_usart uaf_usart_asserts chk (.clk_sys_i, .resetn_i, .reg_sel_i, .reg_wr_i, .reg_rd_i,
  .reg_wdata_i, .reg_rdata_o, .global_int_en_i, .txc_int_ack_i, .serial_in_pin_i,
  .serial_out_pin_o, .rx_int_o, .txc_int_o);
